// ### hdl/tss_params.svh
// Register indices, reset values and timing counts of the supply supervisor
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH
`define TSS_IDX_AMPL 16'hfe58
`define TSS_IDX_CTRL 16'hfe59
`define TSS_IDX_PERSIST 16'hfe5a
`define TSS_IDX_GUARD 16'hfe5b
`define TSS_IDX_CORR1 16'hfe5c
`define TSS_IDX_CORR2 16'hfe5d
`define TSS_IDX_CURTHR 16'hfe5e
`define TSS_IDX_CURGUARD 16'hfe5f
`define TSS_IDX_IRQST 16'hfe60
`define TSS_IDX_IRQMASK 16'hfe61
`define TSS_CTRL_VOLT_EN 0
`define TSS_CTRL_VFAULT 1
`define TSS_CTRL_CONT_CUR 2
`define TSS_CTRL_PFAULT 3
`define TSS_IRQ_PFAULT 0
`define TSS_IRQ_VFAULT 1
`define TSS_RST_CTRL 8'h00
`define TSS_RST_PERSIST 8'h02
`define TSS_RST_GUARD 8'h2d
`define TSS_RST_CORR 8'h00
`define TSS_RST_CURTHR 8'hff
`define TSS_RST_CURGUARD 8'h2d
`define TSS_CLK_NS 10
`define TSS_PERSIST_UNIT_NS 50
`define TSS_PERSIST_TICK (`TSS_PERSIST_UNIT_NS / `TSS_CLK_NS)
`define TSS_GUARD_UNIT_US 50
`define TSS_GUARD_TICK (`TSS_GUARD_UNIT_US * 1000 / `TSS_CLK_NS)
`define TSS_AMPL_LOW 8'h40
`define TSS_AMPL_HIGH 8'hc0
`endif

// ### hdl/tss_pkg.sv
// Types shared by the supply supervisor
package tss_pkg;
  typedef enum logic [1:0] {TSS_IDLE = 2'b01, TSS_TX = 2'b10} tss_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } tss_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tss_apb_rsp_type;
  typedef struct packed {
    logic txStart;
    logic txEnd;
    logic [7:0] txMagnitude;
    logic voltageLow;
    logic [7:0] currentLevel;
  } tss_sense_type;
  typedef struct packed {
    logic [7:0] rssiRaw;
    logic gainControlFirstPath;
    logic gainControlSecondPath;
  } tss_rssi_type;
endpackage

// ### hdl/tss_supervisor.sv
// Transmit supply supervisor with APB register file
// Functional notes
// - Read-only 8-bit amplitude level proportional to emitted signal amplitude.
// - Amplitude level drives an impedance estimate that sets emission configuration.
// - Power failure sets power flag, stops transmission, refuses new ones.
// - Continuous sense 0: measure current once per transmission after guard time.
// - Continuous sense 1: measure current always, idle and transmitting.
// - Voltage failure sets voltage flag, stops transmission, blocks new ones.
// - Voltage sense enable: 0 disables sensing (reset), 1 enables.
// - Voltage failure declared only after persisting programmed 50 ns units.
// - Voltage failures ignored until guard period after transmission start.
// - Guard period counted in 50 us units, reset value 0x2d.
// - First-path RSSI correction applied while first gain path is active.
// - Second-path RSSI correction applied while only the second gain path is active.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "tss_params.svh"
module tss_supervisor #(
  parameter int GUARD_TICK = `TSS_GUARD_TICK
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire tss_pkg::tss_apb_req_type apbReq,
  output tss_pkg::tss_apb_rsp_type apbRsp,
  // Transmit path and supply sense
  input wire tss_pkg::tss_sense_type sense,
  output logic txActive,
  output logic [1:0] emitConfig,
  // Received signal strength
  input wire tss_pkg::tss_rssi_type rssi,
  output logic [7:0] rssiCorrected,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    tss_pkg::tss_state_type state;
    logic txActive;
    logic [7:0] ctrl;
    logic [7:0] persist;
    logic [7:0] guard;
    logic [7:0] corr1;
    logic [7:0] corr2;
    logic [7:0] curThr;
    logic [7:0] curGuard;
    logic [1:0] irqSt;
    logic [1:0] irqMask;
    logic [2:0] div50ns;
    logic [12:0] div50us;
    logic [7:0] guardCnt;
    logic [7:0] failCnt;
    logic measured;
    logic [7:0] peak;
    logic [7:0] ampl;
    logic [1:0] emitCfg;
    logic [7:0] rssiOut;
    tss_pkg::tss_apb_rsp_type rsp;
    logic irq;
  } tss_regs_type;

  tss_regs_type r;
  tss_regs_type next_r;
  logic tick50ns;
  logic tick50us;
  logic access;
  logic wrCtrl;
  logic vArm;
  logic vFailEvt;
  logic pCheck;
  logic pFailEvt;
  logic startOk;

  function automatic logic addrHit(input logic [31:0] addr, input logic [15:0] idx);
    addrHit = addr == {14'h0000, idx, 2'b00};
  endfunction

  function automatic logic [7:0] satAdd(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    satAdd = s[8] ? 8'hff : s[7:0];
  endfunction

  // High amplitude means a light line load, so back the driver off
  function automatic logic [1:0] impedanceStep(input logic [7:0] a);
    if (a < `TSS_AMPL_LOW)
    begin
      impedanceStep = 2'b10;
    end
    else if (a > `TSS_AMPL_HIGH)
    begin
      impedanceStep = 2'b00;
    end
    else
    begin
      impedanceStep = 2'b01;
    end
  endfunction

  always_comb
  begin
    next_r = r;
    tick50ns = r.div50ns == 3'(`TSS_PERSIST_TICK - 1);
    tick50us = r.div50us == 13'(GUARD_TICK - 1);
    access = apbReq.psel && apbReq.penable && r.rsp.pready;
    wrCtrl = access && apbReq.pwrite && addrHit(apbReq.paddr, `TSS_IDX_CTRL);
    vArm = r.txActive && r.ctrl[`TSS_CTRL_VOLT_EN] && r.guardCnt >= r.guard;
    vFailEvt = vArm && sense.voltageLow && r.failCnt >= r.persist;
    if (r.ctrl[`TSS_CTRL_CONT_CUR])
    begin
      pCheck = 1'b1;
    end
    else
    begin
      pCheck = r.txActive && !r.measured && r.guardCnt >= r.curGuard;
    end
    pFailEvt = pCheck && sense.currentLevel > r.curThr;
    // A fault raised in the start cycle refuses that start as well
    startOk = sense.txStart && !r.txActive && !pFailEvt
      && !r.ctrl[`TSS_CTRL_PFAULT] && !r.ctrl[`TSS_CTRL_VFAULT];
    next_r.div50ns = tick50ns ? 3'h0 : r.div50ns + 3'h1;
    // Restarted at each start so the guard counts exactly from it
    next_r.div50us = (tick50us || startOk) ? 13'h0000 : r.div50us + 13'h0001;
    if (!vArm || !sense.voltageLow)
    begin
      next_r.failCnt = 8'h00;
    end
    else if (tick50ns && r.failCnt != 8'hff)
    begin
      next_r.failCnt = r.failCnt + 8'h01;
    end
    if (r.txActive && tick50us && r.guardCnt != 8'hff)
    begin
      next_r.guardCnt = r.guardCnt + 8'h01;
    end
    if (pCheck && !r.ctrl[`TSS_CTRL_CONT_CUR])
    begin
      next_r.measured = 1'b1;
    end
    case (r.state)
      tss_pkg::TSS_IDLE:
      begin
        if (startOk)
        begin
          next_r.state = tss_pkg::TSS_TX;
          next_r.txActive = 1'b1;
          next_r.guardCnt = 8'h00;
          next_r.measured = 1'b0;
          next_r.peak = 8'h00;
        end
      end
      tss_pkg::TSS_TX:
      begin
        if (sense.txMagnitude > r.peak)
        begin
          next_r.peak = sense.txMagnitude;
        end
        if (tick50us)
        begin
          next_r.ampl = r.peak;
          next_r.emitCfg = impedanceStep(r.peak);
          next_r.peak = 8'h00;
        end
        if (sense.txEnd || vFailEvt || pFailEvt)
        begin
          next_r.state = tss_pkg::TSS_IDLE;
          next_r.txActive = 1'b0;
        end
      end
      default:
      begin
        next_r.state = tss_pkg::TSS_IDLE;
        next_r.txActive = 1'b0;
      end
    endcase
    if (access && apbReq.pwrite)
    begin
      if (wrCtrl)
      begin
        next_r.ctrl[`TSS_CTRL_VOLT_EN] = apbReq.pwdata[`TSS_CTRL_VOLT_EN];
        next_r.ctrl[`TSS_CTRL_CONT_CUR] = apbReq.pwdata[`TSS_CTRL_CONT_CUR];
        if (!apbReq.pwdata[`TSS_CTRL_VFAULT])
        begin
          next_r.ctrl[`TSS_CTRL_VFAULT] = 1'b0;
        end
        if (!apbReq.pwdata[`TSS_CTRL_PFAULT])
        begin
          next_r.ctrl[`TSS_CTRL_PFAULT] = 1'b0;
        end
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_PERSIST))
      begin
        next_r.persist = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_GUARD))
      begin
        next_r.guard = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_CORR1))
      begin
        next_r.corr1 = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_CORR2))
      begin
        next_r.corr2 = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_CURTHR))
      begin
        next_r.curThr = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_CURGUARD))
      begin
        next_r.curGuard = apbReq.pwdata[7:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_IRQST))
      begin
        next_r.irqSt = r.irqSt & ~apbReq.pwdata[1:0];
      end
      if (addrHit(apbReq.paddr, `TSS_IDX_IRQMASK))
      begin
        next_r.irqMask = apbReq.pwdata[1:0];
      end
    end
    // Hardware set comes last so it wins over a clear in the same cycle
    if (vFailEvt)
    begin
      next_r.ctrl[`TSS_CTRL_VFAULT] = 1'b1;
      next_r.irqSt[`TSS_IRQ_VFAULT] = 1'b1;
    end
    if (pFailEvt)
    begin
      next_r.ctrl[`TSS_CTRL_PFAULT] = 1'b1;
      next_r.irqSt[`TSS_IRQ_PFAULT] = 1'b1;
    end
    next_r.ctrl[7:4] = 4'h0;
    next_r.irq = |(next_r.irqSt & next_r.irqMask);
    if (rssi.gainControlFirstPath)
    begin
      next_r.rssiOut = satAdd(rssi.rssiRaw, r.corr1);
    end
    else if (rssi.gainControlSecondPath)
    begin
      next_r.rssiOut = satAdd(rssi.rssiRaw, r.corr2);
    end
    else
    begin
      next_r.rssiOut = rssi.rssiRaw;
    end
    next_r.rsp.pready = apbReq.psel && !apbReq.penable;
    if (apbReq.psel && !apbReq.penable)
    begin
      next_r.rsp.pslverr = 1'b0;
      if (addrHit(apbReq.paddr, `TSS_IDX_AMPL))
      begin
        next_r.rsp.prdata = {24'h000000, r.ampl};
        next_r.rsp.pslverr = apbReq.pwrite;
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_CTRL))
      begin
        next_r.rsp.prdata = {24'h000000, r.ctrl};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_PERSIST))
      begin
        next_r.rsp.prdata = {24'h000000, r.persist};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_GUARD))
      begin
        next_r.rsp.prdata = {24'h000000, r.guard};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_CORR1))
      begin
        next_r.rsp.prdata = {24'h000000, r.corr1};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_CORR2))
      begin
        next_r.rsp.prdata = {24'h000000, r.corr2};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_CURTHR))
      begin
        next_r.rsp.prdata = {24'h000000, r.curThr};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_CURGUARD))
      begin
        next_r.rsp.prdata = {24'h000000, r.curGuard};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_IRQST))
      begin
        next_r.rsp.prdata = {30'h00000000, r.irqSt};
      end
      else if (addrHit(apbReq.paddr, `TSS_IDX_IRQMASK))
      begin
        next_r.rsp.prdata = {30'h00000000, r.irqMask};
      end
      else
      begin
        next_r.rsp.prdata = 32'h00000000;
        next_r.rsp.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.state <= tss_pkg::TSS_IDLE;
      r.ctrl <= `TSS_RST_CTRL;
      r.persist <= `TSS_RST_PERSIST;
      r.guard <= `TSS_RST_GUARD;
      r.corr1 <= `TSS_RST_CORR;
      r.corr2 <= `TSS_RST_CORR;
      r.curThr <= `TSS_RST_CURTHR;
      r.curGuard <= `TSS_RST_CURGUARD;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign apbRsp = r.rsp;
  assign txActive = r.txActive;
  assign emitConfig = r.emitCfg;
  assign rssiCorrected = r.rssiOut;
  assign irq = r.irq;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_AMPL_SOURCE: assert property ($changed(r.ampl) |-> $past(tick50us) && $past(r.txActive))
    else $error("Amplitude level changed outside a window tick");
  AST_EMIT_CFG: assert property ($changed(r.ampl) |-> r.emitCfg == impedanceStep(r.ampl))
    else $error("Emission configuration does not match amplitude");
  AST_PFAULT_STOP: assert property ($rose(r.ctrl[`TSS_CTRL_PFAULT]) |-> !r.txActive)
    else $error("Transmission kept running after power fault");
  AST_START_BLOCK: assert property ($rose(r.txActive) |-> $past(r.ctrl[3] == 1'b0 && r.ctrl[1] == 1'b0))
    else $error("Transmission started with a fault flag set");
  AST_CUR_ONCE: assert property ($rose(r.ctrl[3]) && !$past(r.ctrl[2]) |-> $past(r.txActive && !r.measured))
    else $error("Single-shot current check fired outside its slot");
  AST_VFAULT_STOP: assert property ($rose(r.ctrl[`TSS_CTRL_VFAULT]) |-> !r.txActive)
    else $error("Transmission kept running after voltage fault");
  AST_VOLT_OFF: assert property ($rose(r.ctrl[1]) |-> $past(r.ctrl[0]))
    else $error("Voltage fault raised with sensing disabled");
  AST_PERSIST: assert property ($rose(r.ctrl[1]) |-> $past(r.failCnt) >= $past(r.persist))
    else $error("Voltage fault raised before persistence count");
  AST_GUARD: assert property ($rose(r.ctrl[1]) |-> $past(r.guardCnt) >= $past(r.guard))
    else $error("Voltage fault raised inside guard period");
  AST_GUARD_STEP: assert property (r.guardCnt != $past(r.guardCnt) && r.guardCnt != 8'h00 |-> $past(tick50us))
    else $error("Guard counter advanced without a 50 us tick");
  AST_RSSI_FIRST: assert property (rssi.gainControlFirstPath
    |=> r.rssiOut == satAdd($past(rssi.rssiRaw), $past(r.corr1)))
    else $error("First-path RSSI correction wrong");
  AST_RSSI_SECOND: assert property (!rssi.gainControlFirstPath && rssi.gainControlSecondPath
    |=> r.rssiOut == satAdd($past(rssi.rssiRaw), $past(r.corr2)))
    else $error("Second-path RSSI correction wrong");
  AST_STICKY: assert property (r.ctrl[1] && !wrCtrl |=> r.ctrl[1])
    else $error("Voltage fault flag dropped without software clear");

  COV_VFAULT: cover property ($rose(r.ctrl[`TSS_CTRL_VFAULT]));
  COV_PFAULT_CONT: cover property ($rose(r.ctrl[3]) && !$past(r.txActive));
  COV_TX_DONE: cover property ($fell(r.txActive) && !r.ctrl[1] && !r.ctrl[3]);
endmodule

// ### hdl/_unused_guard.sv
// intentionally empty

// ### verification/tss_line_model.sv
// Behavioural line driver and supply sense facing the supervisor
`timescale 1ns/10ps
module tss_line_model
(
  // Clock
  input wire logic clock,
  // Bench commands
  input wire logic startReq,
  input wire logic endReq,
  input wire logic [7:0] level,
  input wire logic lowVolt,
  input wire logic [7:0] current,
  // Block side
  input wire logic txActive,
  output tss_pkg::tss_sense_type sense
);
  // Sense lines lag one cycle, like a real converter
  always @(posedge clock)
  begin
    sense.txStart <= startReq;
    sense.txEnd <= endReq;
    // Nothing emitted while the driver is off
    sense.txMagnitude <= txActive ? level : 8'h00;
    sense.voltageLow <= lowVolt;
    sense.currentLevel <= current;
  end
endmodule

// ### verification/tss_supervisor_tb.sv
// Self-checking bench of the supply supervisor
`timescale 1ns/10ps
module tss_supervisor_tb;
  localparam int TICK = 20;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  tss_pkg::tss_apb_req_type apbReq = '0;
  tss_pkg::tss_apb_rsp_type apbRsp;
  tss_pkg::tss_sense_type sense;
  tss_pkg::tss_rssi_type rssi = '0;
  logic txActive;
  logic [1:0] emitConfig;
  logic [7:0] rssiCorrected;
  logic irq;
  logic startReq = 1'b0;
  logic endReq = 1'b0;
  logic [7:0] level = 8'h00;
  logic lowVolt = 1'b0;
  logic [7:0] current = 8'h00;
  logic [33:0] expQ[$];
  logic [33:0] e;
  logic [7:0] r1, r2, v;
  logic [7:0] lv[3] = '{8'h20, 8'h80, 8'hf0};
  int failures = 0;
  int comparisons = 0;
  int seed = 91;

  always #5 clock = ~clock;

  tss_supervisor #(.GUARD_TICK(TICK)) dut_u (.clock(clock), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp),
    .sense(sense), .txActive(txActive), .emitConfig(emitConfig), .rssi(rssi), .rssiCorrected(rssiCorrected),
    .irq(irq));
  tss_line_model line_u (.clock(clock), .startReq(startReq), .endReq(endReq), .level(level), .lowVolt(lowVolt),
    .current(current), .txActive(txActive), .sense(sense));

  task automatic bad(input string msg);
    failures++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] ex, input string msg);
    comparisons++;
    if (got !== ex)
      bad(msg);
  endtask

  function automatic logic [7:0] sat(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hff : s[7:0];
  endfunction

  // Completed transfers are judged here against the oldest note
  always @(posedge clock)
  begin
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1)
    begin
      e = expQ.pop_front();
      comparisons++;
      if (apbRsp.pslverr !== e[32] || (e[33] && apbRsp.prdata !== {24'h0, e[7:0]}))
        bad("apb response");
    end
  end

  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd, input logic [7:0] ex,
    input logic er);
    expQ.push_back({~wr, er, 24'h0, ex});
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= {14'h0, idx, 2'b00};
    apbReq.pwdata <= {24'h0, wd};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (apbRsp.pready !== 1'b1)
    begin
      @(posedge clock);
    end
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // Idle cycle: read data is latched at setup, so a read must not overlap a write
    @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] ex);
    xfer(1'b0, idx, 8'h00, ex, 1'b0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic pulse(input logic stop);
    if (stop)
      endReq <= 1'b1;
    else
      startReq <= 1'b1;
    @(posedge clock);
    endReq <= 1'b0;
    startReq <= 1'b0;
    cyc(3);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Whole run is some 570 cycles
  initial
  begin
    #300000;
    failures++;
    end_of_test();
  end

  initial
  begin
    cyc(3);
    resetn <= 1'b1;
    @(posedge clock);
    rd(16'hfe58, 8'h00);
    rd(16'hfe59, 8'h00);
    rd(16'hfe5a, 8'h02);
    rd(16'hfe5b, 8'h2d);
    rd(16'hfe5c, 8'h00);
    rd(16'hfe5d, 8'h00);
    xfer(1'b1, 16'hfe58, 8'h5a, 8'h00, 1'b1);
    rd(16'hfe58, 8'h00);
    xfer(1'b0, 16'hfe70, 8'h00, 8'h00, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      v = 8'($random(seed));
      wr(16'hfe5c, r1);
      wr(16'hfe5d, r2);
      rd(16'hfe5c, r1);
      rd(16'hfe5d, r2);
      for (int p = 0; p < 4; p++)
      begin
        rssi <= {v, 2'(p)};
        cyc(3);
        chk(rssiCorrected, sat(v, p[1] ? r1 : p[0] ? r2 : 8'h00), "rssi");
      end
    end
    $display("test rssi done");
    wr(16'hfe5b, 8'h02);
    wr(16'hfe5a, 8'h04);
    wr(16'hfe61, 8'h03);
    wr(16'hfe59, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      level <= lv[k];
      pulse(1'b0);
      cyc(3 * TICK);
      chk(8'(emitConfig), 8'(2 - k), "emit config");
      rd(16'hfe58, lv[k]);
      pulse(1'b1);
      chk(8'(txActive), 8'h00, "tx end");
    end
    $display("test amplitude done");
    // Early dip during guard must be ignored
    lowVolt <= 1'b1;
    pulse(1'b0);
    cyc(TICK);
    lowVolt <= 1'b0;
    cyc(2 * TICK);
    chk(8'(txActive), 8'h01, "guard");
    lowVolt <= 1'b1;
    cyc(14);
    chk(8'(txActive), 8'h01, "persist early");
    cyc(14);
    chk(8'(txActive), 8'h00, "voltage stop");
    lowVolt <= 1'b0;
    rd(16'hfe59, 8'h03);
    chk(8'(irq), 8'h01, "irq set");
    pulse(1'b0);
    chk(8'(txActive), 8'h00, "start refused");
    wr(16'hfe59, 8'h01);
    rd(16'hfe59, 8'h01);
    rd(16'hfe60, 8'h02);
    wr(16'hfe60, 8'h02);
    rd(16'hfe60, 8'h00);
    chk(8'(irq), 8'h00, "irq clear");
    level <= lv[0];
    pulse(1'b0);
    chk(8'(txActive), 8'h01, "restart");
    pulse(1'b1);
    $display("test voltage done");
    wr(16'hfe61, 8'h02);
    wr(16'hfe5e, 8'h80);
    wr(16'hfe59, 8'h05);
    current <= 8'h80;
    cyc(4);
    rd(16'hfe59, 8'h05);
    current <= 8'h81;
    cyc(4);
    current <= 8'h00;
    rd(16'hfe59, 8'h0d);
    chk(8'(irq), 8'h00, "irq masked");
    wr(16'hfe61, 8'h03);
    cyc(2);
    chk(8'(irq), 8'h01, "irq unmasked");
    wr(16'hfe59, 8'h00);
    wr(16'hfe60, 8'h01);
    wr(16'hfe5f, 8'h02);
    current <= 8'hc0;
    cyc(4);
    rd(16'hfe59, 8'h00);
    pulse(1'b0);
    cyc(TICK);
    chk(8'(txActive), 8'h01, "current guard");
    cyc(2 * TICK);
    chk(8'(txActive), 8'h00, "power stop");
    rd(16'hfe59, 8'h08);
    pulse(1'b0);
    chk(8'(txActive), 8'h00, "power refused");
    $display("test current done");
    end_of_test();
  end
endmodule
